// *** fsc_pkg.sv ***
// Shared constants, types and register map for the fan slope control block
package fsc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] FSC_IDX_SLOPE [3] = '{8'h5F, 8'h60, 8'h61};
    localparam logic [7:0] FSC_IDX_ACOU      = 8'h62;
    localparam logic [7:0] FSC_IDX_MIN   [3] = '{8'h64, 8'h65, 8'h66};
    localparam logic [7:0] FSC_IDX_START [3] = '{8'h67, 8'h68, 8'h69};
    localparam logic [7:0] FSC_IDX_CRIT  [3] = '{8'h6A, 8'h6B, 8'h6C};
    localparam logic [7:0] FSC_IDX_HYST_A    = 8'h6D;
    localparam logic [7:0] FSC_IDX_HYST_B    = 8'h6E;
    localparam logic [7:0] FSC_IDX_STATUS    = 8'h70;
    localparam logic [7:0] FSC_IDX_MAX   [3] = '{8'h38, 8'h39, 8'h3A};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FSC_SLOPE_LSB   = 4;
    localparam int FSC_HYST_HI_LSB = 4;
    localparam int FSC_HYST_LO_LSB = 0;
    localparam int FSC_KEEP_LSB    = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FSC_SLOPE_RST  = 8'hC0;
    localparam logic [7:0] FSC_CRIT_RST   = 8'hA4;
    localparam logic [7:0] FSC_HYST_A_RST = 8'h44;
    localparam logic [7:0] FSC_HYST_B_RST = 8'h40;
    localparam logic [7:0] FSC_ACOU_RST   = 8'h00;
    localparam logic [7:0] FSC_MIN_RST    = 8'h80;
    localparam logic [7:0] FSC_MAX_RST    = 8'hFF;
    localparam logic [7:0] FSC_START_RST  = 8'h5A;

    // ------------------------------------------------------------
    // Duty arithmetic
    // ------------------------------------------------------------
    localparam logic [7:0]  FSC_FULL_DUTY = 8'hFF;
    localparam logic [7:0]  FSC_OFF_DUTY  = 8'h00;
    // 170 duty codes per span, span held in sixths of a degree
    localparam logic [17:0] FSC_SLOPE_K   = 18'h003FC;
    localparam logic [8:0]  FSC_SPAN6 [16] = '{
        9'h00C, 9'h00F, 9'h014, 9'h018, 9'h01E, 9'h028, 9'h030, 9'h03C,
        9'h050, 9'h060, 9'h078, 9'h0A0, 9'h0C0, 9'h0F0, 9'h140, 9'h1E0};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FSC_FAN_OFF  = 2'b00,
        FSC_FAN_RAMP = 2'b01,
        FSC_FAN_HOLD = 2'b10
    } fsc_fan_e;

    typedef struct packed {
        logic       override;
        logic       fan_on;
        logic       ramp;
        logic [7:0] temp;
    } fsc_chan_st_s;

endpackage : fsc_pkg

// *** fsc_channel.sv ***
// Per-channel evaluation state and ramp duty arithmetic
`timescale 1ns/1ps
`default_nettype none

module fsc_channel (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // Monitoring cycle
    input  wire logic                 tick,
    input  wire logic [7:0]           temp,
    // Configuration
    input  wire logic [7:0]           start,
    input  wire logic [7:0]           crit,
    input  wire logic [3:0]           hyst,
    // State
    output fsc_pkg::fsc_chan_st_s     st
);
    fsc_pkg::fsc_fan_e state;
    fsc_pkg::fsc_fan_e next_state;
    logic              ov;
    logic              next_ov;
    logic [7:0]        temp_q;

    wire [8:0] t_hy    = {1'b0, temp} + {5'h00, hyst};
    wire       hot     = temp > start;
    wire       cold    = t_hy < {1'b0, start};
    wire       crit_hi = temp > crit;
    wire       crit_lo = t_hy < {1'b0, crit};

    // ------------------------------------------------------------
    // Fan on/off with hysteresis below start
    // ------------------------------------------------------------
    always_comb begin
        case (state)
            fsc_pkg::FSC_FAN_OFF:  next_state = hot ? fsc_pkg::FSC_FAN_RAMP
                                                    : fsc_pkg::FSC_FAN_OFF;
            fsc_pkg::FSC_FAN_RAMP: next_state = hot ? fsc_pkg::FSC_FAN_RAMP
                                   : cold ? fsc_pkg::FSC_FAN_OFF
                                          : fsc_pkg::FSC_FAN_HOLD;
            fsc_pkg::FSC_FAN_HOLD: next_state = hot ? fsc_pkg::FSC_FAN_RAMP
                                   : cold ? fsc_pkg::FSC_FAN_OFF
                                          : fsc_pkg::FSC_FAN_HOLD;
            default:               next_state = fsc_pkg::FSC_FAN_OFF;
        endcase
    end

    // Same hysteresis releases the override
    assign next_ov = crit_hi ? 1'b1 : (crit_lo ? 1'b0 : ov);

    // ------------------------------------------------------------
    // Evaluated once per monitoring cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state  <= fsc_pkg::FSC_FAN_OFF;
            ov     <= 1'b0;
            temp_q <= 8'h00;
        end else if (tick) begin
            state  <= next_state;
            ov     <= next_ov;
            temp_q <= temp;
        end
    end

    assign st = '{override: ov,
                  fan_on:   state != fsc_pkg::FSC_FAN_OFF,
                  ramp:     state == fsc_pkg::FSC_FAN_RAMP,
                  temp:     temp_q};

endmodule : fsc_channel

module fsc_duty_calc (
    // Operands
    input  wire logic [7:0] temp,
    input  wire logic [7:0] start,
    input  wire logic [3:0] slope,
    input  wire logic [7:0] min_duty,
    input  wire logic [7:0] max_duty,
    // Result
    output logic [7:0]      duty
);
    wire [7:0]  delta = (temp > start) ? 8'(temp - start) : 8'h00;
    wire [17:0] num   = 18'({10'h000, delta} * fsc_pkg::FSC_SLOPE_K);
    wire [17:0] step  = num / {9'h000, fsc_pkg::FSC_SPAN6[slope]};
    wire [18:0] sum   = {11'h000, min_duty} + {1'b0, step};
    // Full duty is code 255
    wire [7:0]  full  = (sum > {11'h000, fsc_pkg::FSC_FULL_DUTY})
                        ? fsc_pkg::FSC_FULL_DUTY : sum[7:0];

    assign duty = (full > max_duty) ? max_duty : full;

endmodule : fsc_duty_calc

`default_nettype wire

// *** fsc_fan_control.sv ***
// Automatic fan duty control with slope, hysteresis and critical override
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Each channel has its own four-bit slope code in bits 7:4.
// - Slope codes map 2 to 80 degrees; reset code selects 32.
// - Slope registers sit at 0x5F, 0x60 and 0x61.
// - At 33% minimum, full duty comes at start plus span.
// - Slope stays fixed; effective span scales with 255 minus minimum.
// - Any channel above its critical limit drives all fans full.
// - Override holds until temperature drops below limit minus hysteresis.
// - Override ignores every automatic control setting.
// - Critical limits at 0x6A to 0x6C reset to 0xA4.
// - Hysteresis fields: 0x6D high and low nibbles, 0x6E high nibble.
// - Hysteresis in whole degrees, each field resets to four.
// - Fan stays on until temperature drops hysteresis below start.
// - One hysteresis per channel serves fan off and override release.
// - Bits 7:5 of 0x62 keep fans at minimum; hysteresis moot.
// - Bit 4+n cleared gives zero duty, set gives minimum duty.
// - Full duty taken as code 255, minimum as programmed code.
// - Maximum clamp applies only without critical override.
module fsc_fan_control (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Monitoring cycle
    input  wire logic        monitor_tick,
    input  wire logic [7:0]  temp_remote1,
    input  wire logic [7:0]  temp_local,
    input  wire logic [7:0]  temp_remote2,
    // Fan outputs
    output logic      [7:0]  fan_drive_1,
    output logic      [7:0]  fan_drive_2,
    output logic      [7:0]  fan_drive_3,
    output logic             critical_overtemp
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] slope_reg [3];
    logic [7:0] crit_reg  [3];
    logic [7:0] min_reg   [3];
    logic [7:0] max_reg   [3];
    logic [7:0] start_reg [3];
    logic [7:0] hyst_a;
    logic [7:0] hyst_b;
    logic [7:0] acou;
    logic [7:0] drive     [3];
    logic       ov_any_q;

    fsc_pkg::fsc_chan_st_s st [3];
    logic [7:0] temp_v   [3];
    logic [3:0] hyst_v   [3];
    logic [3:0] slope_v  [3];
    logic [7:0] auto_v   [3];
    logic [7:0] next_drv [3];
    logic [2:0] ov_vec;
    logic [2:0] on_vec;
    logic [2:0] keep_v;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [7:0] idx      = paddr[9:2];
    wire       aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire       setup    = psel && !penable;
    wire       access   = psel && penable;
    wire       is_stat  = idx == fsc_pkg::FSC_IDX_STATUS;
    wire       is_acou  = idx == fsc_pkg::FSC_IDX_ACOU;
    wire       is_hya   = idx == fsc_pkg::FSC_IDX_HYST_A;
    wire       is_hyb   = idx == fsc_pkg::FSC_IDX_HYST_B;
    logic [2:0] is_slope;
    logic [2:0] is_crit;
    logic [2:0] is_min;
    logic [2:0] is_max;
    logic [2:0] is_start;
    wire       hit      = aligned && (is_stat || is_acou || is_hya || is_hyb
                          || (|is_slope) || (|is_crit) || (|is_min)
                          || (|is_max) || (|is_start));
    wire       wr_go    = access && pwrite && pstrb[0] && hit && !is_stat;

    assign pready  = 1'b1;
    assign pslverr = access && !hit;

    // ------------------------------------------------------------
    // Single registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hyst_a <= fsc_pkg::FSC_HYST_A_RST;
            hyst_b <= fsc_pkg::FSC_HYST_B_RST;
            acou   <= fsc_pkg::FSC_ACOU_RST;
        end else begin
            if (wr_go && is_hya)
                hyst_a <= pwdata[7:0];
            if (wr_go && is_hyb)
                hyst_b <= pwdata[7:0];
            if (wr_go && is_acou)
                acou <= pwdata[7:0];
        end
    end

    assign hyst_v[0] = hyst_a[fsc_pkg::FSC_HYST_HI_LSB +: 4];
    assign hyst_v[1] = hyst_a[fsc_pkg::FSC_HYST_LO_LSB +: 4];
    assign hyst_v[2] = hyst_b[fsc_pkg::FSC_HYST_HI_LSB +: 4];
    assign keep_v    = acou[fsc_pkg::FSC_KEEP_LSB +: 3];
    assign temp_v[0] = temp_remote1;
    assign temp_v[1] = temp_local;
    assign temp_v[2] = temp_remote2;

    // ------------------------------------------------------------
    // Per-channel registers, evaluation and duty
    // ------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_ch
        assign is_slope[i] = idx == fsc_pkg::FSC_IDX_SLOPE[i];
        assign is_crit[i]  = idx == fsc_pkg::FSC_IDX_CRIT[i];
        assign is_min[i]   = idx == fsc_pkg::FSC_IDX_MIN[i];
        assign is_max[i]   = idx == fsc_pkg::FSC_IDX_MAX[i];
        assign is_start[i] = idx == fsc_pkg::FSC_IDX_START[i];

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                slope_reg[i] <= fsc_pkg::FSC_SLOPE_RST;
                crit_reg[i]  <= fsc_pkg::FSC_CRIT_RST;
                min_reg[i]   <= fsc_pkg::FSC_MIN_RST;
                max_reg[i]   <= fsc_pkg::FSC_MAX_RST;
                start_reg[i] <= fsc_pkg::FSC_START_RST;
            end else begin
                if (wr_go && is_slope[i])
                    slope_reg[i] <= pwdata[7:0];
                if (wr_go && is_crit[i])
                    crit_reg[i] <= pwdata[7:0];
                if (wr_go && is_min[i])
                    min_reg[i] <= pwdata[7:0];
                if (wr_go && is_max[i])
                    max_reg[i] <= pwdata[7:0];
                if (wr_go && is_start[i])
                    start_reg[i] <= pwdata[7:0];
            end
        end

        assign slope_v[i] = slope_reg[i][fsc_pkg::FSC_SLOPE_LSB +: 4];

        fsc_channel u_chan (
            .clock (clock),
            .rst   (rst),
            .tick  (monitor_tick),
            .temp  (temp_v[i]),
            .start (start_reg[i]),
            .crit  (crit_reg[i]),
            .hyst  (hyst_v[i]),
            .st    (st[i])
        );

        fsc_duty_calc u_calc (
            .temp     (st[i].temp),
            .start    (start_reg[i]),
            .slope    (slope_v[i]),
            .min_duty (min_reg[i]),
            .max_duty (max_reg[i]),
            .duty     (auto_v[i])
        );

        assign ov_vec[i] = st[i].override;
        assign on_vec[i] = st[i].fan_on;

        // Override first, then ramp, hold band or keep, then off
        assign next_drv[i] = (|ov_vec) ? fsc_pkg::FSC_FULL_DUTY
                           : st[i].ramp ? auto_v[i]
                           : (st[i].fan_on || keep_v[i]) ? min_reg[i]
                           : fsc_pkg::FSC_OFF_DUTY;

        always_ff @(posedge clock or posedge rst) begin
            if (rst)
                drive[i] <= fsc_pkg::FSC_OFF_DUTY;
            else
                drive[i] <= next_drv[i];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            ov_any_q <= 1'b0;
        else
            ov_any_q <= |ov_vec;
    end

    assign fan_drive_1       = drive[0];
    assign fan_drive_2       = drive[1];
    assign fan_drive_3       = drive[2];
    assign critical_overtemp = ov_any_q;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        for (int k = 0; k < 3; k++) begin
            if (is_slope[k])
                rd_mux = slope_reg[k];
            if (is_crit[k])
                rd_mux = crit_reg[k];
            if (is_min[k])
                rd_mux = min_reg[k];
            if (is_max[k])
                rd_mux = max_reg[k];
            if (is_start[k])
                rd_mux = start_reg[k];
        end
        if (is_acou)
            rd_mux = acou;
        if (is_hya)
            rd_mux = hyst_a;
        if (is_hyb)
            rd_mux = hyst_b;
        if (is_stat)
            rd_mux = {1'b0, |ov_vec, on_vec, ov_vec};
        if (!aligned)
            rd_mux = 8'h00;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            prdata <= 32'h00000000;
        else if (setup && !pwrite)
            prdata <= {24'h000000, rd_mux};
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_over;
        |ov_vec;
    endsequence

    sequence s_all_full;
        (fan_drive_1 == 8'hFF) && (fan_drive_2 == 8'hFF)
            && (fan_drive_3 == 8'hFF);
    endsequence

    sequence s_bus_write;
        psel && penable && pwrite && pstrb[0];
    endsequence

    a_override_all_full: assert property (
        s_over |=> s_all_full ##0 critical_overtemp)
        else $error("override did not drive all fans full");

    for (genvar i = 0; i < 3; i++) begin : g_chk
        a_crit_enter: assert property (
            monitor_tick && (temp_v[i] > crit_reg[i]) |=> ov_vec[i] ##1 s_all_full)
            else $error("critical limit did not start override");

        a_crit_hold_hyst: assert property (
            ov_vec[i] && monitor_tick
            && ({1'b0, temp_v[i]} + {5'h00, hyst_v[i]} >= {1'b0, crit_reg[i]})
            |=> ov_vec[i])
            else $error("override released above limit minus hysteresis");

        a_eval_tick_only: assert property (
            !monitor_tick |=> $stable(ov_vec[i]) && $stable(on_vec[i]))
            else $error("channel state changed without monitor tick");

        a_fan_hyst_hold: assert property (
            on_vec[i] && monitor_tick && (temp_v[i] <= start_reg[i])
            && ({1'b0, temp_v[i]} + {5'h00, hyst_v[i]} >= {1'b0, start_reg[i]})
            |=> on_vec[i])
            else $error("fan switched off inside hysteresis band");

        a_keep_min_duty: assert property (
            !(|ov_vec) && !st[i].ramp && keep_v[i] |=> drive[i] == $past(min_reg[i]))
            else $error("kept fan not at minimum duty");

        a_off_zero_duty: assert property (
            !(|ov_vec) && !on_vec[i] && !keep_v[i] |=> drive[i] == 8'h00)
            else $error("fan not off below start minus hysteresis");

        a_clamp_max_auto: assert property (
            !(|ov_vec) && st[i].ramp |=> drive[i] <= $past(max_reg[i]))
            else $error("automatic duty above maximum clamp");

        a_full_at_span: assert property (
            !(|ov_vec) && st[i].ramp && (max_reg[i] == 8'hFF)
            && (st[i].temp > start_reg[i])
            && (20'(st[i].temp - start_reg[i]) * 20'd1020
                >= 20'(8'hFF - min_reg[i]) * 20'(fsc_pkg::FSC_SPAN6[slope_v[i]]))
            |=> drive[i] == 8'hFF)
            else $error("full duty not reached at effective span");

        a_crit_release: assert property (
            ov_vec[i] && monitor_tick && (temp_v[i] <= crit_reg[i])
            && ({1'b0, temp_v[i]} + {5'h00, hyst_v[i]} < {1'b0, crit_reg[i]})
            |=> !ov_vec[i])
            else $error("override held below limit minus hysteresis");

        a_fan_off_cold: assert property (
            monitor_tick && (temp_v[i] <= start_reg[i])
            && ({1'b0, temp_v[i]} + {5'h00, hyst_v[i]} < {1'b0, start_reg[i]})
            |=> !on_vec[i])
            else $error("fan still on below start minus hysteresis");

        a_fan_on_hot: assert property (
            monitor_tick && (temp_v[i] > start_reg[i]) |=> st[i].ramp)
            else $error("fan not ramping above start temperature");

        a_ramp_min_floor: assert property (
            !(|ov_vec) && st[i].ramp && (min_reg[i] <= max_reg[i])
            |=> drive[i] >= $past(min_reg[i]))
            else $error("ramp duty below minimum duty");

        a_crit_write: assert property (
            s_bus_write ##0 (paddr == {2'h0, fsc_pkg::FSC_IDX_CRIT[i], 2'h0})
            |=> crit_reg[i] == $past(pwdata[7:0]))
            else $error("critical limit write did not land");

        a_slope_write: assert property (
            s_bus_write ##0 (paddr == {2'h0, fsc_pkg::FSC_IDX_SLOPE[i], 2'h0})
            |=> slope_reg[i] == $past(pwdata[7:0]))
            else $error("slope write did not land");
    end

endmodule : fsc_fan_control

`default_nettype wire

// *** fsc_sensor_model.sv ***
// Sensor channel model: conversion results and monitoring tick
`timescale 1ns/1ps
`default_nettype none

module fsc_sensor_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Conversion request
    input  wire logic       conv,
    input  wire logic [7:0] t_r1,
    input  wire logic [7:0] t_loc,
    input  wire logic [7:0] t_r2,
    // Results
    output logic            tick,
    output logic      [7:0] temp_r1,
    output logic      [7:0] temp_loc,
    output logic      [7:0] temp_r2
);
    // Latest result stays until the next conversion
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick     <= 1'b0;
            temp_r1  <= 8'h00;
            temp_loc <= 8'h00;
            temp_r2  <= 8'h00;
        end else begin
            tick <= conv;
            if (conv) begin
                temp_r1  <= t_r1;
                temp_loc <= t_loc;
                temp_r2  <= t_r2;
            end
        end
    end
endmodule : fsc_sensor_model

`default_nettype wire

// *** tb.sv ***
// Self-checking testbench of the fan slope control block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        conv, tick, smp, ovt;
    logic [7:0]  t1, tl, t2, tr1, tlo, tr2, f1, f2, f3, r;
    logic [32:0] note_q [$];
    int          n_errors, tests_run, i;

    always #5 clock = ~clock;

    fsc_sensor_model fsc_sensor_model_i (.clock(clock), .rst(rst),
        .conv(conv), .t_r1(t1), .t_loc(tl), .t_r2(t2), .tick(tick),
        .temp_r1(tr1), .temp_loc(tlo), .temp_r2(tr2));

    fsc_fan_control fsc_fan_control_i (.clock(clock), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .monitor_tick(tick), .temp_remote1(tr1),
        .temp_local(tlo), .temp_remote2(tr2), .fan_drive_1(f1),
        .fan_drive_2(f2), .fan_drive_3(f3), .critical_overtemp(ovt));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task report_and_stop;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0
            && pready === 1'b1 && note_q.size() > 0)
            chk({pslverr, prdata}, note_q.pop_front());
        if (smp === 1'b1 && note_q.size() > 0)
            chk({8'h00, ovt, f3, f2, f1}, note_q.pop_front());
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            n_errors++;
            report_and_stop;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] idx, input logic [7:0] d, input logic e);
        note_q.push_back({e, 24'h000000, d});
        apb(1'b0, idx, 8'h00);
    endtask : rd

    task conv_t(input logic [7:0] a, input logic [7:0] b,
                input logic [7:0] c);
        @(posedge clock);
        t1   <= a;
        tl   <= b;
        t2   <= c;
        conv <= 1'b1;
        @(posedge clock);
        conv <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : conv_t

    task fans(input logic [7:0] a, input logic [7:0] b,
              input logic [7:0] c, input logic o);
        note_q.push_back({8'h00, o, c, b, a});
        @(posedge clock);
        smp <= 1'b1;
        @(posedge clock);
        smp <= 1'b0;
    endtask : fans

    function automatic logic [7:0] ramp(input logic [7:0] t,
        input logic [7:0] s, input logic [7:0] mn, input logic [3:0] c);
        int d;
        d = int'(mn) + (int'(t) - int'(s)) * 1020 / fsc_pkg::FSC_SPAN6[c];
        if (d > 255) d = 255;
        return d[7:0];
    endfunction : ramp

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        clock = 0; rst = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; pstrb = 4'hF; conv = 0; smp = 0;
        t1 = 8'h20; tl = 8'h20; t2 = 8'h20;
        n_errors = 0; tests_run = 0;
        void'($urandom(24));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 3; i++) begin
            rd(fsc_pkg::FSC_IDX_SLOPE[i], 8'hC0, 1'b0);
            rd(fsc_pkg::FSC_IDX_CRIT[i], 8'hA4, 1'b0);
        end
        rd(8'h6D, 8'h44, 1'b0);
        rd(8'h6E, 8'h40, 1'b0);
        rd(8'h01, 8'h00, 1'b1);
        fans(8'h00, 8'h00, 8'h00, 1'b0);
        apb(1'b1, 8'h64, 8'h55);
        for (i = 0; i < 16; i++) begin
            apb(1'b1, 8'h5F, {i[3:0], 4'h0});
            rd(8'h5F, {i[3:0], 4'h0}, 1'b0);
            r = 8'd90 + 8'($urandom_range(40, 1));
            conv_t(r, 8'h20, 8'h20);
            fans(ramp(r, 8'd90, 8'h55, i[3:0]), 8'h00, 8'h00,
                 1'b0);
        end
        apb(1'b1, 8'h5F, 8'hC0);
        conv_t(8'd122, 8'h20, 8'h20);
        fans(8'hFF, 8'h00, 8'h00, 1'b0);
        conv_t(8'd121, 8'h20, 8'h20);
        fans(8'hF9, 8'h00, 8'h00, 1'b0);
        apb(1'b1, 8'h64, 8'h80);
        conv_t(8'd105, 8'h20, 8'h20);
        fans(8'hCF, 8'h00, 8'h00, 1'b0);
        apb(1'b1, 8'h64, 8'h55);
        apb(1'b1, 8'h38, 8'h90);
        conv_t(8'd122, 8'h20, 8'h20);
        fans(8'h90, 8'h00, 8'h00, 1'b0);
        apb(1'b1, 8'h6D, 8'h48);
        conv_t(8'd122, 8'd165, 8'h20);
        fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
        rd(8'h70, 8'h5A, 1'b0);
        conv_t(8'd122, 8'd159, 8'h20);
        fans(8'hFF, 8'hFF, 8'hFF, 1'b1);
        conv_t(8'd122, 8'd155, 8'h20);
        fans(8'h90, 8'hFF, 8'h00, 1'b0);
        conv_t(8'd88, 8'd155, 8'h20);
        fans(8'h55, 8'hFF, 8'h00, 1'b0);
        conv_t(8'd85, 8'd155, 8'h20);
        fans(8'h00, 8'hFF, 8'h00, 1'b0);
        apb(1'b1, 8'h62, 8'hA0);
        conv_t(8'd85, 8'd155, 8'h20);
        fans(8'h55, 8'hFF, 8'h80, 1'b0);
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop;
    end
endmodule : tb

`default_nettype wire
